// >>> rtl/bssi_pkg.sv
// register map, field positions, reset values and timing for the battery switchover block
package bssi_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_IRQ_EN_PRI2      = 8'hA9;
  localparam logic [7:0] IDX_SUPPLY_IRQ_EN    = 8'hEC;
  localparam logic [7:0] IDX_SUPPLY_IRQ_FLAGS = 8'hF8;
  localparam logic [7:0] IDX_PERIPHERAL_CFG   = 8'hF4;
  localparam logic [7:0] IDX_SWITCHOVER_CFG   = 8'hF5;
  localparam logic [7:0] IDX_IRQ_PIN_CFG      = 8'hFF;
  localparam logic [7:0] IDX_DELTA_THR        = 8'hF3;
  localparam logic [7:0] IDX_CONV_START       = 8'hD8;
  localparam logic [7:0] IDX_BAT_THR          = 8'hFA;
  localparam logic [7:0] IDX_BAT_READING      = 8'hDF;
  localparam logic [7:0] IDX_DCIN_READING     = 8'hEF;
  localparam logic [7:0] IDX_MONITOR_CTRL     = 8'hE1;

  // field positions
  localparam int GLOBAL_IRQ_EN_BIT  = 1;
  localparam int FLAG_RESTORE       = 7;
  localparam int FLAG_SAG           = 5;
  localparam int FLAG_DCIN_DELTA    = 3;
  localparam int FLAG_BATTERY       = 2;
  localparam int FLAG_SWITCHOVER    = 1;
  localparam int FLAG_DCIN_LOW      = 0;
  localparam logic [7:0] FLAG_MASK  = 8'hAF;
  localparam int SWCFG_DISABLE_BIT  = 1;
  localparam int SWCFG_TRIG_LSB     = 2;
  localparam int SOURCE_BIT         = 6;
  localparam int INT1_CFG_LSB       = 2;
  localparam logic [1:0] INT1_BATTERY_PIN = 2'h1;
  localparam int MONCTL_READY_BIT   = 0;
  localparam int MONCTL_BAT_ALL_BIT = 4;

  // reset values
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] SWCFG_RST = 8'h04;

  // timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned SLOW_TICK_NS      = 1_000_000;
  localparam int unsigned SLOW_TICK_CYC     = SLOW_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DCIN_PERIOD_TICKS = 1000;
  localparam int unsigned VDD_QUAL_TICKS    = 16;
  localparam int unsigned DCIN_QUAL_TICKS   = 16;

  typedef enum logic {BSSI_ON_MAIN, BSSI_ON_BATT} bssi_src_type;
endpackage

// >>> rtl/bssi_qualify.sv
// qualification timer: level must stay good for a number of slow ticks
`timescale 1ns/1ps
module bssi_qualify #(
  parameter int unsigned TICKS = 16
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_tick,
  input  wire logic i_good,
  output logic      o_qualified
);
  logic [15:0] cnt_q;
  wire logic   done = (cnt_q >= 16'(TICKS));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q       <= 16'h0000;
      o_qualified <= 1'b0;
    end else begin
      // any dip restarts the whole qualification time
      if (!i_good) begin
        cnt_q <= 16'h0000;
      end else if (i_tick && !done) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      o_qualified <= i_good && done;
    end
  end
endmodule // bssi_qualify

// >>> rtl/bssi_sync.sv
// two-flop synchroniser for comparator outputs and the battery-control pin
`timescale 1ns/1ps
module bssi_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // bssi_sync

// >>> rtl/bssi_top.sv
// battery switchover sequencer with the shared supply-event interrupt
// Notes on behaviour
// - switchover on by default; config bit 1 set keeps supply on main
// - peripheral config bit 6 reads 1 on main supply, 0 on battery
// - trigger select 00 enables switchover on low DC input; off by default
// - trigger select bit 1 clear enables switchover on low main supply
// - battery-control pin rising edge switches to battery when pin function enabled
// - return to main only when every enabled trigger is false or switchover is disabled
// - with DC trigger, both DC input and main must stay good qualified time
// - with only main trigger, main must stay good qualified time
// - with pin enabled, return also needs the pin low
// - global supply interrupt enable is clear after reset
// - per-event enable register picks which flags drive the interrupt
// - flags stay latched until software writes zero to them
// - main-to-battery change sets the switchover flag
// - battery-to-main change sets the restore flag
// - switchover and restore flags set regardless of their enables
// - DC readings differing by more than delta threshold set a flag
// - periodic DC conversions, write to start register launches one, ready flag
// - battery flag on reading below threshold or on each new reading
// - DC comparator flag set while DC input is below its reference
// - sag flag set on sag event from the metering engine
// - metering converters marked unavailable while on battery
`timescale 1ns/1ps
module bssi_top #(
  parameter int unsigned SLOW_DIV    = bssi_pkg::SLOW_TICK_CYC,
  parameter int unsigned DCIN_PERIOD = bssi_pkg::DCIN_PERIOD_TICKS
) (
  input  wire logic [bssi_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [bssi_pkg::DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [bssi_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                             o_avs_waitrequest,
  input  wire logic                        i_dcin_low_cmp,
  input  wire logic                        i_vdd_low_cmp,
  input  wire logic                        i_battery_control_pin,
  input  wire logic                        i_dcin_adc_valid,
  input  wire logic [bssi_pkg::REG_W-1:0]  i_dcin_adc_data,
  input  wire logic                        i_bat_adc_valid,
  input  wire logic [bssi_pkg::REG_W-1:0]  i_bat_adc_data,
  input  wire logic                        i_sag_event,
  output logic                             o_on_battery,
  output logic                             o_meter_adc_enable,
  output logic                             o_dcin_conv_start,
  output logic                             o_power_supply_monitor_irq
);
  import bssi_pkg::*;

  localparam int DIV_W = $clog2(SLOW_DIV);
  localparam int PER_W = $clog2(DCIN_PERIOD);

  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  function automatic logic [7:0] abs_delta(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // register storage
  logic [7:0]   irq_enable_priority_two_q;
  logic [7:0]   supply_irq_enable_q;
  logic [7:0]   supply_irq_flags_q;
  logic [7:0]   peripheral_config_q;
  logic [7:0]   switchover_config_q;
  logic [7:0]   irq_pin_config_q;
  logic [7:0]   adc_delta_threshold_q;
  logic [7:0]   battery_threshold_q;
  logic [7:0]   battery_reading_q;
  logic [7:0]   dcin_reading_q;
  logic         dcin_have_prev_q;
  logic         dcin_ready_q;
  logic         bat_every_reading_q;
  logic         pin_prev_q;
  logic [DIV_W-1:0] div_q;
  logic [PER_W-1:0] per_q;
  bssi_src_type state_q;
  bssi_src_type state_d;
  logic [2:0]   synced;
  logic         vdd_qual;
  logic         dcin_qual;

  // bus access decode
  wire logic [7:0] sel_idx  = i_avs_address[ADDR_W-1:2];
  wire logic       rd_acc   = i_avs_read & ~o_avs_waitrequest;
  wire logic       wr_acc   = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire logic [7:0] wdat     = i_avs_writedata[7:0];
  wire logic       wr_ien2  = wr_acc & idx_hit(sel_idx, IDX_IRQ_EN_PRI2);
  wire logic       wr_ien   = wr_acc & idx_hit(sel_idx, IDX_SUPPLY_IRQ_EN);
  wire logic       wr_flags = wr_acc & idx_hit(sel_idx, IDX_SUPPLY_IRQ_FLAGS);
  wire logic       wr_perif = wr_acc & idx_hit(sel_idx, IDX_PERIPHERAL_CFG);
  wire logic       wr_swcfg = wr_acc & idx_hit(sel_idx, IDX_SWITCHOVER_CFG);
  wire logic       wr_pincf = wr_acc & idx_hit(sel_idx, IDX_IRQ_PIN_CFG);
  wire logic       wr_delta = wr_acc & idx_hit(sel_idx, IDX_DELTA_THR);
  wire logic       wr_start = wr_acc & idx_hit(sel_idx, IDX_CONV_START);
  wire logic       wr_bthr  = wr_acc & idx_hit(sel_idx, IDX_BAT_THR);
  wire logic       wr_monct = wr_acc & idx_hit(sel_idx, IDX_MONITOR_CTRL);

  // synchronised inputs
  wire logic dcin_low_s = synced[0];
  wire logic vdd_low_s  = synced[1];
  wire logic pin_s      = synced[2];
  wire logic pin_rise   = pin_s & ~pin_prev_q;

  // trigger selection
  wire logic [1:0] trig_sel    = switchover_config_q[SWCFG_TRIG_LSB +: 2];
  wire logic       sw_disable  = switchover_config_q[SWCFG_DISABLE_BIT];
  wire logic       dcin_trig   = (trig_sel == 2'h0);
  wire logic       vdd_trig    = ~trig_sel[1];
  wire logic       pin_trig    = (irq_pin_config_q[INT1_CFG_LSB +: 2] == INT1_BATTERY_PIN);
  wire logic       go_battery  = ~sw_disable & ((dcin_trig & dcin_low_s)
                                 | (vdd_trig & vdd_low_s)
                                 | (pin_trig & pin_rise));
  // a disable while on battery forces the supply home at once
  wire logic       may_return  = sw_disable
                                 | (((~dcin_trig & ~vdd_trig) | vdd_qual)
                                 & (~dcin_trig | dcin_qual)
                                 & (~pin_trig | ~pin_s));

  always_comb begin
    state_d = state_q;
    case (state_q)
      BSSI_ON_MAIN: if (go_battery) state_d = BSSI_ON_BATT;
      BSSI_ON_BATT: if (may_return) state_d = BSSI_ON_MAIN;
      default:      state_d = BSSI_ON_MAIN;
    endcase
  end

  // slow always-on tick and background conversion period
  wire logic tick      = (div_q == DIV_W'(SLOW_DIV - 1));
  wire logic per_done  = tick & (per_q == PER_W'(DCIN_PERIOD - 1));
  wire logic conv_go   = per_done | wr_start;

  // event sources for the flag register
  wire logic switch_ev = (state_q == BSSI_ON_MAIN) & (state_d == BSSI_ON_BATT);
  wire logic restor_ev = (state_q == BSSI_ON_BATT) & (state_d == BSSI_ON_MAIN);
  wire logic delta_ev  = i_dcin_adc_valid & dcin_have_prev_q
                         & (abs_delta(i_dcin_adc_data, dcin_reading_q) > adc_delta_threshold_q);
  wire logic bat_ev    = i_bat_adc_valid
                         & (bat_every_reading_q | (i_bat_adc_data < battery_threshold_q));
  wire logic [7:0] flag_set = {restor_ev, 1'b0, i_sag_event, 1'b0,
                               delta_ev, bat_ev, switch_ev, dcin_low_s};
  // a set in the same cycle as a clear wins
  wire logic [7:0] flag_keep = wr_flags ? (supply_irq_flags_q & wdat)
                                        : supply_irq_flags_q;
  wire logic [7:0] flags_d   = (flag_keep | flag_set) & FLAG_MASK;
  wire logic       irq_d     = irq_enable_priority_two_q[GLOBAL_IRQ_EN_BIT]
                               & |(supply_irq_flags_q & supply_irq_enable_q);
  wire logic       ready_d   = i_dcin_adc_valid
                               | (dcin_ready_q & ~(wr_monct & ~wdat[MONCTL_READY_BIT]));

  // read selection; unmapped indices read zero
  wire logic [7:0] src_view = {peripheral_config_q[7], (state_q == BSSI_ON_MAIN),
                               peripheral_config_q[5:0]};
  wire logic [7:0] monctl_v = {3'h0, bat_every_reading_q, 3'h0, dcin_ready_q};
  wire logic [7:0] rd_mux   =
      idx_hit(sel_idx, IDX_IRQ_EN_PRI2)      ? irq_enable_priority_two_q :
      idx_hit(sel_idx, IDX_SUPPLY_IRQ_EN)    ? supply_irq_enable_q :
      idx_hit(sel_idx, IDX_SUPPLY_IRQ_FLAGS) ? supply_irq_flags_q :
      idx_hit(sel_idx, IDX_PERIPHERAL_CFG)   ? src_view :
      idx_hit(sel_idx, IDX_SWITCHOVER_CFG)   ? switchover_config_q :
      idx_hit(sel_idx, IDX_IRQ_PIN_CFG)      ? irq_pin_config_q :
      idx_hit(sel_idx, IDX_DELTA_THR)        ? adc_delta_threshold_q :
      idx_hit(sel_idx, IDX_BAT_THR)          ? battery_threshold_q :
      idx_hit(sel_idx, IDX_BAT_READING)      ? battery_reading_q :
      idx_hit(sel_idx, IDX_DCIN_READING)     ? dcin_reading_q :
      idx_hit(sel_idx, IDX_MONITOR_CTRL)     ? monctl_v : REG_RST;

  bssi_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_battery_control_pin, i_vdd_low_cmp, i_dcin_low_cmp}),
    .o_sync  (synced)
  );

  bssi_qualify #(
    .TICKS (VDD_QUAL_TICKS)
  ) u_vdd_qual (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_tick      (tick),
    .i_good      (~vdd_low_s),
    .o_qualified (vdd_qual)
  );

  bssi_qualify #(
    .TICKS (DCIN_QUAL_TICKS)
  ) u_dcin_qual (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_tick      (tick),
    .i_good      (~dcin_low_s),
    .o_qualified (dcin_qual)
  );

  // bus handshake: one wait cycle, read data captured while waiting
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= o_avs_waitrequest ? ~(i_avs_read | i_avs_write) : 1'b1;
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= {{(DATA_W - REG_W){1'b0}}, rd_mux};
      end
    end
  end

  // software-written configuration
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable_priority_two_q <= REG_RST;
      supply_irq_enable_q       <= REG_RST;
      peripheral_config_q       <= REG_RST;
      switchover_config_q       <= SWCFG_RST;
      irq_pin_config_q          <= REG_RST;
      adc_delta_threshold_q     <= REG_RST;
      battery_threshold_q       <= REG_RST;
      bat_every_reading_q       <= 1'b0;
    end else begin
      if (wr_ien2)  irq_enable_priority_two_q <= wdat;
      if (wr_ien)   supply_irq_enable_q       <= wdat;
      if (wr_perif) peripheral_config_q       <= wdat;
      if (wr_swcfg) switchover_config_q       <= wdat;
      if (wr_pincf) irq_pin_config_q          <= wdat;
      if (wr_delta) adc_delta_threshold_q     <= wdat;
      if (wr_bthr)  battery_threshold_q       <= wdat;
      if (wr_monct) bat_every_reading_q       <= wdat[MONCTL_BAT_ALL_BIT];
    end
  end

  // supply source, flags and monitor readings
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q            <= BSSI_ON_MAIN;
      supply_irq_flags_q <= REG_RST;
      dcin_ready_q       <= 1'b0;
      pin_prev_q         <= 1'b0;
    end else begin
      state_q            <= state_d;
      supply_irq_flags_q <= flags_d;
      dcin_ready_q       <= ready_d;
      pin_prev_q         <= pin_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dcin_reading_q    <= REG_RST;
      dcin_have_prev_q  <= 1'b0;
      battery_reading_q <= REG_RST;
    end else begin
      if (i_dcin_adc_valid) dcin_reading_q    <= i_dcin_adc_data;
      if (i_dcin_adc_valid) dcin_have_prev_q  <= 1'b1;
      if (i_bat_adc_valid)  battery_reading_q <= i_bat_adc_data;
    end
  end

  // dividers and registered outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q                      <= '0;
      per_q                      <= '0;
      o_on_battery               <= 1'b0;
      o_meter_adc_enable         <= 1'b1;
      o_dcin_conv_start          <= 1'b0;
      o_power_supply_monitor_irq <= 1'b0;
    end else begin
      div_q                      <= tick ? '0 : div_q + DIV_W'(1);
      if (tick) per_q            <= per_done ? '0 : per_q + PER_W'(1);
      o_on_battery               <= (state_d == BSSI_ON_BATT);
      o_meter_adc_enable         <= (state_d == BSSI_ON_MAIN);
      o_dcin_conv_start          <= conv_go;
      o_power_supply_monitor_irq <= irq_d;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  disable_keeps_main_a: assert property (sw_disable |=> state_q == BSSI_ON_MAIN)
    else $error("switchover disabled but supply left on battery");
  source_bit_read_a: assert property (
      rd_acc && idx_hit(sel_idx, IDX_PERIPHERAL_CFG)
      |-> o_avs_readdata[SOURCE_BIT] == $past(state_q == BSSI_ON_MAIN))
    else $error("source bit does not match supply source");
  dcin_trigger_a: assert property (
      state_q == BSSI_ON_MAIN && !sw_disable && dcin_trig && dcin_low_s
      |=> state_q == BSSI_ON_BATT ##1 o_on_battery)
    else $error("low DC input did not switch to battery");
  vdd_trigger_a: assert property (
      state_q == BSSI_ON_MAIN && !sw_disable && vdd_trig && vdd_low_s
      |=> state_q == BSSI_ON_BATT)
    else $error("low main supply did not switch to battery");
  pin_trigger_a: assert property (
      state_q == BSSI_ON_MAIN && !sw_disable && pin_trig && pin_s && !$past(pin_s)
      |=> state_q == BSSI_ON_BATT)
    else $error("pin edge did not switch to battery");
  return_needs_clear_a: assert property (
      state_q == BSSI_ON_BATT ##1 state_q == BSSI_ON_MAIN |-> $past(may_return))
    else $error("returned to main with a trigger still active");
  dcin_qual_hold_a: assert property (
      state_q == BSSI_ON_BATT && !sw_disable && dcin_trig && !dcin_qual
      |=> state_q == BSSI_ON_BATT)
    else $error("returned before DC input qualified");
  vdd_qual_hold_a: assert property (
      state_q == BSSI_ON_BATT && !sw_disable && vdd_trig && !vdd_qual
      |=> state_q == BSSI_ON_BATT)
    else $error("returned before main supply qualified");
  pin_high_hold_a: assert property (
      state_q == BSSI_ON_BATT && !sw_disable && pin_trig && pin_s
      |=> state_q == BSSI_ON_BATT)
    else $error("returned while battery-control pin high");
  irq_gating_a: assert property (
      !irq_enable_priority_two_q[GLOBAL_IRQ_EN_BIT] ||
      !(|(supply_irq_flags_q & supply_irq_enable_q)) |=> !o_power_supply_monitor_irq)
    else $error("interrupt raised without enabled flag");
  flags_latched_a: assert property (
      !wr_flags |=> (supply_irq_flags_q & $past(supply_irq_flags_q))
                    == $past(supply_irq_flags_q))
    else $error("flag dropped without software clear");
  switch_flag_a: assert property (switch_ev |=> supply_irq_flags_q[FLAG_SWITCHOVER])
    else $error("switchover flag not set");
  restore_flag_a: assert property (restor_ev |=> supply_irq_flags_q[FLAG_RESTORE])
    else $error("restore flag not set");
  meter_off_a: assert property (
      state_q == BSSI_ON_BATT && state_d == BSSI_ON_BATT |-> !o_meter_adc_enable [*2])
    else $error("metering converters enabled on battery");
  conv_start_a: assert property (wr_start |=> o_dcin_conv_start)
    else $error("start write did not launch a conversion");

  switch_seen_c:  cover property (switch_ev);
  restore_seen_c: cover property (restor_ev);
  irq_seen_c:     cover property ($rose(o_power_supply_monitor_irq));
  delta_seen_c:   cover property (delta_ev);
endmodule // bssi_top

// >>> tb/bssi_supply_model.sv
// supply monitor ADCs and sag source on the far side of the block
`timescale 1ns/1ps
module bssi_supply_model (
  input  wire logic       i_clk,
  input  wire logic       i_conv_start,
  output logic            o_dc_valid,
  output logic      [7:0] o_dc_data,
  output logic            o_bat_valid,
  output logic      [7:0] o_bat_data,
  output logic            o_sag
);
  logic [7:0] dc_lvl = 8'h20;
  initial {o_dc_valid, o_dc_data, o_bat_valid, o_bat_data, o_sag} = 19'h0_0000;
  // reading one cycle after each launch; data inverted while not valid
  always @(posedge i_clk) begin
    o_dc_valid <= i_conv_start;
    o_dc_data  <= i_conv_start ? dc_lvl : ~dc_lvl;
  end
  // s set gives a sag pulse, else one battery reading of v
  task automatic pulse(input logic s, input logic [7:0] v);
    {o_bat_valid, o_sag, o_bat_data} <= {~s, s, v};
    @(posedge i_clk);
    {o_bat_valid, o_sag, o_bat_data} <= {2'h0, ~v};
  endtask
endmodule // bssi_supply_model

// >>> tb/tb_top.sv
// self-checking bench for the battery switchover sequencer
`timescale 1ns/1ps
module tb_top;
  logic        i_clk, i_rst_n, rd, wr, dc, vdd, pin, wreq, on_bat, meter, conv, irq, dv, bv, sag;
  logic  [7:0] dd, bd;
  logic  [9:0] adr;
  logic [31:0] wd, rdata;
  int          err_total, cmp_count;
  // op: 0 read, 1 write, 2 {dc,vdd,pin}, 3 wait source, 4 pulse, 5 irq, 6 meter, 7 dc,
  // 8 idle, 9 conversion start at next edge, a mid-run reset
  logic [19:0] plan [$] = {
    20'h0_F504, 20'h0_A900, 20'h0_1000,
    20'h0_F440, 20'h1_A902, 20'h1_ECAF,
    20'h2_0002, 20'h3_0001, 20'h0_F802,
    20'h0_F400, 20'h6_0000, 20'h5_0001,
    20'h1_EC00, 20'h1_F8FF, 20'h0_F802, 20'h5_0000,
    20'h2_0000, 20'h3_0000, 20'h6_0001, 20'h0_F882,
    20'h1_FF04, 20'h2_0001, 20'h3_0001, 20'h8_0064, 20'h3_0001,
    20'h2_0000, 20'h3_0000, 20'h1_F506, 20'h2_0002, 20'h8_0014, 20'h3_0000,
    20'h2_0000, 20'h1_F500, 20'h1_F800, 20'h2_0004, 20'h3_0001,
    20'h2_0000, 20'h3_0000, 20'h0_F883,
    20'h1_FA80, 20'h1_F305, 20'h1_F800, 20'h4_0010,
    20'h7_0030, 20'h1_D800, 20'h9_0001, 20'h8_0004, 20'h0_F80C,
    20'h0_E101, 20'h4_0110, 20'h8_0002, 20'h0_F82C,
    20'h1_F800, 20'h4_0090, 20'h8_0002, 20'h0_F800, 20'h0_DF90, 20'h0_EF30,
    20'h1_E110, 20'h4_0090, 20'h8_0002, 20'h0_F804,
    20'h1_ECAF, 20'h1_A900, 20'h8_0002, 20'h5_0000,
    20'h1_A902, 20'h8_0002, 20'h5_0001, 20'hA_0000, 20'h0_F504, 20'h0_F800,
    20'h0_A900, 20'h0_EC00, 20'h3_0000, 20'h5_0000
  };
  bssi_top #(.SLOW_DIV(4), .DCIN_PERIOD(4)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_dcin_low_cmp(dc),
    .i_vdd_low_cmp(vdd), .i_battery_control_pin(pin), .i_dcin_adc_valid(dv),
    .i_dcin_adc_data(dd), .i_bat_adc_valid(bv), .i_bat_adc_data(bd), .i_sag_event(sag),
    .o_on_battery(on_bat), .o_meter_adc_enable(meter), .o_dcin_conv_start(conv),
    .o_power_supply_monitor_irq(irq));
  bssi_supply_model u_sup (.i_clk(i_clk), .i_conv_start(conv), .o_dc_valid(dv),
    .o_dc_data(dd), .o_bat_valid(bv), .o_bat_data(bd), .o_sag(sag));
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // request held until waitrequest is sampled low at an edge
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n = 0;
    @(posedge i_clk);
    {rd, wr, adr, wd} <= {~w, w, i, 2'h0, 24'h00_0000, d};
    do @(posedge i_clk); while (wreq !== 1'h0 && ++n < 50);
    {rd, wr} <= 2'h0;
    if (!w) chk($sformatf("reg %h", i), d, rdata[7:0]);
    if (wreq !== 1'h0) chk("waitrequest", 8'h00, 8'h01);
    if (wreq !== 1'h0) tally_and_finish;
  endtask
  task automatic ws(input logic v);
    int n = 0;
    while (on_bat !== v && n++ < 300) @(posedge i_clk);
    chk("on_battery", {7'h00, v}, {7'h00, on_bat});
    if (on_bat !== v) tally_and_finish;
  endtask
  task automatic step(input logic [19:0] s);
    case (s[19:16])
      4'h0: acc(1'h0, s[15:8], s[7:0]);
      4'h1: acc(1'h1, s[15:8], s[7:0]);
      4'h2: {dc, vdd, pin} <= s[2:0];
      4'h3: ws(s[0]);
      4'h4: u_sup.pulse(s[8], s[7:0]);
      4'h5: chk("irq", s[7:0], {7'h00, irq});
      4'h6: chk("meter_en", s[7:0], {7'h00, meter});
      4'h7: u_sup.dc_lvl <= s[7:0];
      4'h9: begin
        @(posedge i_clk);
        chk("conv_start", s[7:0], {7'h00, conv});
      end
      4'hA: begin
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'h1;
      end
      default: repeat (s[7:0]) @(posedge i_clk);
    endcase
  endtask
  initial begin
    {i_rst_n, rd, wr, dc, vdd, pin, adr, wd} = 48'h0000_0000_0000;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'h1;
    foreach (plan[k]) step(plan[k]);
    tally_and_finish;
  end
endmodule // tb_top
